// >>> inc/pin_mux_pkg.sv
package pin_mux_pkg;

    // ------------------------------------------------------------
    // Pin indices
    // ------------------------------------------------------------
    localparam int PIN_N           = 12;
    localparam int PIN_PORT0_BIT0  = 0;
    localparam int PIN_PORT0_BIT1  = 1;
    localparam int PIN_PORT0_BIT2  = 2;
    localparam int PIN_PORT1_BIT1  = 3;
    localparam int PIN_PORT1_BIT2  = 4;
    localparam int PIN_PORT1_BIT3  = 5;
    localparam int PIN_PORT2_BIT0  = 6;
    localparam int PIN_PORT2_BIT1  = 7;
    localparam int PIN_PORT3_BIT0  = 8;
    localparam int PIN_PORT3_BIT1  = 9;
    localparam int PIN_PORT_D_BIT2 = 10;
    localparam int PIN_PORT_D_BIT3 = 11;

    // ------------------------------------------------------------
    // Synchroniser lanes: the pins, then the two mode pins
    // ------------------------------------------------------------
    localparam int SYNC_W          = PIN_N + 2;
    localparam int SYNC_PROG_SUPPLY = PIN_N;
    localparam int SYNC_RESET_PIN  = PIN_N + 1;

    // ------------------------------------------------------------
    // Programming link
    // ------------------------------------------------------------
    localparam int PROG_WORD_W     = 8;
    localparam int PROG_CNT_W      = 3;
    localparam logic [PROG_CNT_W-1:0] PROG_CNT_LAST = 3'h7;
    localparam logic [PROG_CNT_W-1:0] PROG_CNT_RST  = 3'h0;
    localparam logic [PROG_WORD_W-1:0] PROG_WORD_RST = 8'h00;

    // ------------------------------------------------------------
    // Carriers
    // ------------------------------------------------------------
    typedef struct packed {
        logic out;
        logic oe;
    } pad_drive_t;

    localparam pad_drive_t PAD_DRIVE_RST = '{out: 1'b0, oe: 1'b0};

    typedef struct packed {
        logic sio_rx_en;
        logic sio_tx_en;
        logic sio_tx_data;
        logic sio_clk_en;
        logic sio_clk_out_sel;
        logic sio_clk_out;
        logic t1_en;
        logic t1_out_sel;
        logic t1_out;
        logic t0_en;
        logic t0_out_sel;
        logic t0_out;
        logic int_en;
    } periph_ctl_t;

    typedef struct packed {
        logic serial_rx;
        logic sio_clk_in;
        logic t1_in;
        logic t0_in;
        logic int_in;
    } periph_in_t;

    localparam periph_in_t PERIPH_IN_RST = '{default: 1'b0};

    typedef enum logic [1:0] {
        LINK_IDLE,
        LINK_PROGRAM,
        LINK_READ
    } link_state_t;

endpackage

// >>> hw/pin_sync.sv
`timescale 1ns/1ns
module pin_sync
    import pin_mux_pkg::*;
#(
    parameter int W = 1
) (
    input  wire logic         ref_clk,
    input  wire logic         sys_rst,
    input  wire logic [W-1:0] raw,
    output logic      [W-1:0] level
);

    logic [W-1:0] stage1;
    logic [W-1:0] stage2;
    logic [W-1:0] stage3;

    always_ff @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            stage1 <= '0;
            stage2 <= '0;
            stage3 <= '0;
        end else begin
            stage1 <= raw;
            stage2 <= stage1;
            stage3 <= stage2;
        end
    end

    // A lane changes only once the second and third stages agree
    always_ff @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            level <= '0;
        end else begin
            for (int i = 0; i < W; i++) begin
                if (stage2[i] == stage3[i]) begin
                    level[i] <= stage3[i];
                end
            end
        end
    end

endmodule

// >>> hw/pin_cell.sv
`timescale 1ns/1ns
module pin_cell
    import pin_mux_pkg::*;
(
    input  wire logic       port_out,
    input  wire logic       port_dir,
    input  wire logic       periph_own,
    input  wire logic       periph_out,
    input  wire logic       prog_mode,
    input  wire logic       prog_use,
    input  wire pad_drive_t prog_drive,
    output pad_drive_t      drive
);

    always_comb begin
        if (prog_mode) begin
            // Pins the link does not use float while programming
            drive = prog_use ? prog_drive : PAD_DRIVE_RST;
        end else if (periph_own) begin
            drive.out = periph_out;
            drive.oe  = 1'b1;
        end else begin
            drive.out = port_out;
            drive.oe  = port_dir;
        end
    end

endmodule

// >>> hw/shared_pin_function_mux.sv
// Functional notes
// - Port2 bit0 is two-way programming data
// - Port2 bit1 is sampled programming clock
// - Port D bit3 selects read or program
// - Port0 bit0 stays in/out with serial receive
// - Port0 bit1 readable while serial transmit drives
// - Port0 bit2 readable while serial clock used
// - Port1 bit1 usable with timer1 count pin
// - Port1 bit2 usable with timer0 count pin
// - Port1 bit3 in/out with external interrupt
// - Analog-shared pins keep digital in/out
`timescale 1ns/1ns
module shared_pin_function_mux
    import pin_mux_pkg::*;
(
    input  wire logic                   ref_clk,
    input  wire logic                   sys_rst,
    input  wire logic [PIN_N-1:0]       pad_in,
    output pad_drive_t [PIN_N-1:0]      pad_drive,
    input  wire logic                   prog_supply_pin,
    input  wire logic                   reset_pin,
    input  wire logic [PIN_N-1:0]       port_latch,
    input  wire logic [PIN_N-1:0]       port_dir,
    output logic      [PIN_N-1:0]       port_rd,
    input  wire periph_ctl_t            periph_ctl,
    output periph_in_t                  periph_in,
    output logic                        prog_mode,
    output logic                        prog_pulse,
    output logic [PROG_WORD_W-1:0]      prog_word,
    output logic                        prog_word_valid,
    input  wire logic [PROG_WORD_W-1:0] prog_tx_word,
    output logic                        prog_tx_taken
);

    // ------------------------------------------------------------
    // Pin sampling
    // ------------------------------------------------------------
    logic [SYNC_W-1:0] sync_raw;
    logic [SYNC_W-1:0] sync_level;
    logic [PIN_N-1:0]  pin_level;

    assign sync_raw = {reset_pin, prog_supply_pin, pad_in};

    pin_sync #(
        .W       (SYNC_W)
    ) u_pin_sync (
        .ref_clk (ref_clk),
        .sys_rst (sys_rst),
        .raw     (sync_raw),
        .level   (sync_level)
    );

    assign pin_level = sync_level[PIN_N-1:0];

    // ------------------------------------------------------------
    // Writing mode detection
    // ------------------------------------------------------------
    logic mode_req;

    // Entry needs the supply pin raised and reset held low
    assign mode_req = sync_level[SYNC_PROG_SUPPLY] & ~sync_level[SYNC_RESET_PIN];

    always_ff @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            prog_mode <= 1'b0;
        end else begin
            prog_mode <= mode_req;
        end
    end

    // ------------------------------------------------------------
    // Programming link
    // ------------------------------------------------------------
    link_state_t             link_state;
    logic                    sclk_prev;
    logic                    sclk_rise;
    logic                    sclk_fall;
    logic                    pulse_prev;
    logic [PROG_CNT_W-1:0]   bit_cnt;
    logic [PROG_WORD_W-1:0]  rx_shift;
    logic [PROG_WORD_W-1:0]  tx_shift;
    logic                    sda_out;
    pad_drive_t              link_sda;

    assign sclk_rise = pin_level[PIN_PORT2_BIT1] & ~sclk_prev;
    assign sclk_fall = ~pin_level[PIN_PORT2_BIT1] & sclk_prev;

    always_ff @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            sclk_prev  <= 1'b0;
            pulse_prev <= 1'b0;
            prog_pulse <= 1'b0;
        end else begin
            sclk_prev  <= pin_level[PIN_PORT2_BIT1];
            pulse_prev <= pin_level[PIN_PORT_D_BIT3];
            prog_pulse <= prog_mode & pin_level[PIN_PORT_D_BIT3];
        end
    end

    // High pulse level writes into the device, low level reads it out
    always_ff @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            link_state <= LINK_IDLE;
        end else if (!prog_mode) begin
            link_state <= LINK_IDLE;
        end else begin
            case (link_state)
                LINK_IDLE: begin
                    link_state <= pin_level[PIN_PORT_D_BIT3] ? LINK_PROGRAM : LINK_READ;
                end
                LINK_PROGRAM: begin
                    if (!pin_level[PIN_PORT_D_BIT3]) begin
                        link_state <= LINK_READ;
                    end
                end
                LINK_READ: begin
                    if (pin_level[PIN_PORT_D_BIT3]) begin
                        link_state <= LINK_PROGRAM;
                    end
                end
                default: begin
                    link_state <= LINK_IDLE;
                end
            endcase
        end
    end

    // Bit counter restarts whenever the operation changes
    always_ff @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            bit_cnt <= PROG_CNT_RST;
        end else if (!prog_mode || (pulse_prev != pin_level[PIN_PORT_D_BIT3])) begin
            bit_cnt <= PROG_CNT_RST;
        end else if (sclk_rise && link_state != LINK_IDLE) begin
            bit_cnt <= bit_cnt + 1'b1;
        end
    end

    // Program: data sampled on clock rise, most significant bit first
    always_ff @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            rx_shift        <= PROG_WORD_RST;
            prog_word       <= PROG_WORD_RST;
            prog_word_valid <= 1'b0;
        end else begin
            prog_word_valid <= 1'b0;
            if (link_state == LINK_PROGRAM && sclk_rise) begin
                rx_shift <= {rx_shift[PROG_WORD_W-2:0], pin_level[PIN_PORT2_BIT0]};
                if (bit_cnt == PROG_CNT_LAST) begin
                    prog_word       <= {rx_shift[PROG_WORD_W-2:0], pin_level[PIN_PORT2_BIT0]};
                    prog_word_valid <= 1'b1;
                end
            end
        end
    end

    // Read: word loaded before the first bit and again at the eighth clock fall, shifted out on clock fall
    always_ff @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            tx_shift      <= PROG_WORD_RST;
            sda_out       <= 1'b0;
            prog_tx_taken <= 1'b0;
        end else begin
            prog_tx_taken <= 1'b0;
            if (link_state != LINK_READ) begin
                tx_shift <= prog_tx_word;
                sda_out  <= prog_tx_word[PROG_WORD_W-1];
            end else if (sclk_fall) begin
                if (bit_cnt == PROG_CNT_RST) begin
                    tx_shift      <= prog_tx_word;
                    sda_out       <= prog_tx_word[PROG_WORD_W-1];
                    prog_tx_taken <= 1'b1;
                end else begin
                    tx_shift <= {tx_shift[PROG_WORD_W-2:0], 1'b0};
                    sda_out  <= tx_shift[PROG_WORD_W-2];
                end
            end
        end
    end

    // Data line is driven only during a read
    assign link_sda.out = sda_out;
    assign link_sda.oe  = (link_state == LINK_READ);

    // ------------------------------------------------------------
    // Peripheral ownership of shared pins
    // ------------------------------------------------------------
    logic [PIN_N-1:0] periph_own;
    logic [PIN_N-1:0] periph_out;
    logic [PIN_N-1:0] prog_use;
    pad_drive_t [PIN_N-1:0] prog_drive;
    pad_drive_t [PIN_N-1:0] next_pad_drive;

    // Input-only functions never take the output away from the port
    always_comb begin
        periph_own = '0;
        periph_out = '0;
        periph_own[PIN_PORT0_BIT1] = periph_ctl.sio_tx_en;
        periph_out[PIN_PORT0_BIT1] = periph_ctl.sio_tx_data;
        periph_own[PIN_PORT0_BIT2] = periph_ctl.sio_clk_en & periph_ctl.sio_clk_out_sel;
        periph_out[PIN_PORT0_BIT2] = periph_ctl.sio_clk_out;
        periph_own[PIN_PORT1_BIT1] = periph_ctl.t1_en & periph_ctl.t1_out_sel;
        periph_out[PIN_PORT1_BIT1] = periph_ctl.t1_out;
        periph_own[PIN_PORT1_BIT2] = periph_ctl.t0_en & periph_ctl.t0_out_sel;
        periph_out[PIN_PORT1_BIT2] = periph_ctl.t0_out;
    end

    always_comb begin
        prog_use   = '0;
        prog_drive = '{default: PAD_DRIVE_RST};
        prog_use[PIN_PORT2_BIT0]   = 1'b1;
        prog_drive[PIN_PORT2_BIT0] = link_sda;
        prog_use[PIN_PORT2_BIT1]   = 1'b1;
        prog_use[PIN_PORT_D_BIT3]  = 1'b1;
    end

    genvar g;
    generate
        for (g = 0; g < PIN_N; g++) begin : g_cell
            pin_cell u_pin_cell (
                .port_out   (port_latch[g]),
                .port_dir   (port_dir[g]),
                .periph_own (periph_own[g]),
                .periph_out (periph_out[g]),
                .prog_mode  (prog_mode),
                .prog_use   (prog_use[g]),
                .prog_drive (prog_drive[g]),
                .drive      (next_pad_drive[g])
            );
        end
    endgenerate

    // Analog-shared pins pass through the plain port path
    always_ff @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            pad_drive <= '{default: PAD_DRIVE_RST};
        end else begin
            pad_drive <= next_pad_drive;
        end
    end

    // ------------------------------------------------------------
    // Read-back and peripheral inputs
    // ------------------------------------------------------------
    always_ff @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            port_rd <= '0;
        end else begin
            port_rd <= pin_level;
        end
    end

    always_ff @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            periph_in <= PERIPH_IN_RST;
        end else begin
            periph_in.serial_rx  <= periph_ctl.sio_rx_en & pin_level[PIN_PORT0_BIT0];
            periph_in.sio_clk_in <= periph_ctl.sio_clk_en & ~periph_ctl.sio_clk_out_sel
                                    & pin_level[PIN_PORT0_BIT2];
            periph_in.t1_in      <= periph_ctl.t1_en & ~periph_ctl.t1_out_sel
                                    & pin_level[PIN_PORT1_BIT1];
            periph_in.t0_in      <= periph_ctl.t0_en & ~periph_ctl.t0_out_sel
                                    & pin_level[PIN_PORT1_BIT2];
            periph_in.int_in     <= periph_ctl.int_en & pin_level[PIN_PORT1_BIT3];
        end
    end

endmodule

// >>> sim/shared_pin_function_mux_checker.sv
`timescale 1ns/1ns
module shared_pin_function_mux_checker
    import pin_mux_pkg::*;
(
    input wire logic                   ref_clk,
    input wire logic                   sys_rst,
    input wire logic [PIN_N-1:0]       pad_in,
    input wire pad_drive_t [PIN_N-1:0] pad_drive,
    input wire logic                   prog_supply_pin,
    input wire logic                   reset_pin,
    input wire logic [PIN_N-1:0]       port_latch,
    input wire logic [PIN_N-1:0]       port_dir,
    input wire logic [PIN_N-1:0]       port_rd,
    input wire periph_ctl_t            periph_ctl,
    input wire periph_in_t             periph_in,
    input wire logic                   prog_mode,
    input wire logic                   prog_pulse,
    input wire logic [PROG_WORD_W-1:0] prog_word,
    input wire logic                   prog_word_valid,
    input wire logic [PROG_WORD_W-1:0] prog_tx_word,
    input wire logic                   prog_tx_taken
);
    logic [3:0]       up_cnt;
    logic             was_prog;
    logic             settled;
    logic             normal;
    logic [PIN_N-1:0] oe_vec;

    // ------------------------------------------------------------
    // Helpers: time since reset, previous mode, enable vector
    // ------------------------------------------------------------
    always_ff @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            up_cnt <= 4'h0;
        end else if (up_cnt != 4'h8) begin
            up_cnt <= up_cnt + 4'h1;
        end
    end
    always_ff @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            was_prog <= 1'b0;
        end else begin
            was_prog <= prog_mode;
        end
    end
    assign settled = (up_cnt == 4'h8);
    assign normal = settled && !prog_mode && !was_prog;
    always_comb begin
        for (int i = 0; i < PIN_N; i++) begin
            oe_vec[i] = pad_drive[i].oe;
        end
    end

    function automatic logic kept(pad_drive_t d, logic l, logic dir);
        return (d.oe == dir) && (!dir || d.out == l);
    endfunction

    default clocking @(posedge ref_clk); endclocking
    default disable iff (sys_rst);

    a_pin_read_back: assert property (settled && $stable(pad_in)[*7] |-> port_rd == pad_in)
        else $error("port read differs from pin");
    a_rx_port_kept: assert property (normal && $past(periph_ctl.sio_rx_en)
        |-> kept(pad_drive[0], $past(port_latch[0]), $past(port_dir[0]))) else $error("rx pin lost port drive");
    a_tx_drives_pin: assert property (normal && $past(periph_ctl.sio_tx_en)
        |-> pad_drive[1] == {$past(periph_ctl.sio_tx_data), 1'b1}) else $error("tx pin drive wrong");
    a_sck_in_seen: assert property (settled && $stable({pad_in, periph_ctl})[*7] && periph_ctl.sio_clk_en
        && !periph_ctl.sio_clk_out_sel |-> periph_in.sio_clk_in == pad_in[2]) else $error("clock input wrong");
    a_t1_in_kept: assert property (normal && $past(periph_ctl.t1_en && !periph_ctl.t1_out_sel)
        |-> kept(pad_drive[3], $past(port_latch[3]), $past(port_dir[3]))) else $error("t1 pin lost port drive");
    a_t0_out_drive: assert property (normal && $past(periph_ctl.t0_en && periph_ctl.t0_out_sel)
        |-> pad_drive[4] == {$past(periph_ctl.t0_out), 1'b1}) else $error("t0 pin drive wrong");
    a_int_sees_pin: assert property (settled && $stable({pad_in, periph_ctl})[*7] && periph_ctl.int_en
        |-> periph_in.int_in == pad_in[5]) else $error("interrupt input wrong");
    a_analog_kept: assert property (normal |-> kept(pad_drive[8], $past(port_latch[8]), $past(port_dir[8]))
        && kept(pad_drive[11], $past(port_latch[11]), $past(port_dir[11]))) else $error("analog pin drive lost");
    a_prog_pins_float: assert property (prog_mode && was_prog |-> (oe_vec & 12'hfbf) == 12'h000)
        else $error("pin driven in writing mode");
    a_pulse_tracks: assert property (settled && prog_mode && was_prog && $stable(pad_in[11])[*7]
        |-> prog_pulse == pad_in[11]) else $error("pulse level wrong");
    a_mode_entry: assert property (settled && $stable({prog_supply_pin, reset_pin})[*7]
        |-> prog_mode == (prog_supply_pin && !reset_pin)) else $error("writing mode wrong");
    a_word_strobe: assert property (prog_word_valid |=> !prog_word_valid && $stable(prog_word))
        else $error("word strobe too long");
    a_load_strobe: assert property (prog_tx_taken |=> !prog_tx_taken)
        else $error("load strobe too long");

    c_word: cover property (prog_word_valid);
    c_load: cover property (prog_tx_taken);
    c_tx_own: cover property (normal && periph_ctl.sio_tx_en);
endmodule

bind shared_pin_function_mux shared_pin_function_mux_checker shared_pin_function_mux_checker_inst (
    .ref_clk, .sys_rst, .pad_in, .pad_drive, .prog_supply_pin, .reset_pin, .port_latch, .port_dir, .port_rd,
    .periph_ctl, .periph_in, .prog_mode, .prog_pulse, .prog_word, .prog_word_valid, .prog_tx_word, .prog_tx_taken
);

// >>> sim/prog_model.sv
`timescale 1ns/1ns
module prog_model
    import pin_mux_pkg::*;
(
    input  wire logic       ref_clk,
    input  wire pad_drive_t data_drive,
    output logic            prog_supply_pin,
    output logic            reset_pin,
    output logic            link_clk,
    output logic            pulse_pin,
    output logic            data_pin
);
    logic drv_on;
    logic drv_bit;
    logic last;

    initial begin
        prog_supply_pin = 1'b0;
        reset_pin = 1'b1;
        link_clk = 1'b0;
        pulse_pin = 1'b0;
        drv_on = 1'b0;
        drv_bit = 1'b0;
        last = 1'b0;
    end

    // Released data line shows a changing pattern, not the last bit
    always @(posedge ref_clk) last <= data_pin;
    always_comb data_pin = data_drive.oe ? data_drive.out : (drv_on ? drv_bit : ~last);

    task automatic pause(input int n);
        repeat (n) @(negedge ref_clk);
    endtask

    task automatic enter;
        prog_supply_pin = 1'b1;
        reset_pin = 1'b0;
        pause(8);
    endtask

    task automatic leave;
        prog_supply_pin = 1'b0;
        reset_pin = 1'b1;
        pause(8);
    endtask

    task automatic send_word(input logic [7:0] w);
        pulse_pin = 1'b1;
        pause(8);
        for (int i = 7; i >= 0; i--) begin
            drv_on = 1'b1;
            drv_bit = w[i];
            pause(4);
            link_clk = 1'b1;
            pause(4);
            link_clk = 1'b0;
        end
        pause(4);
        drv_on = 1'b0;
    endtask

    // Slow reader: msb stands before the first rise, each later bit after a fall
    task automatic read_word(output logic [7:0] w);
        pulse_pin = 1'b0;
        pause(8);
        for (int i = 7; i >= 0; i--) begin
            w[i] = data_pin;
            link_clk = 1'b1;
            pause(4);
            link_clk = 1'b0;
            pause(8);
        end
    endtask
endmodule

// >>> sim/test_shared_pin_function_mux.sv
`timescale 1ns/1ns
module test_shared_pin_function_mux
    import pin_mux_pkg::*;
;
    logic                        ref_clk;
    logic                        sys_rst;
    logic [PIN_N-1:0]            pins;
    logic [PIN_N-1:0]            pad_in;
    pad_drive_t [PIN_N-1:0]      pad_drive;
    logic                        supply;
    logic                        rst_pin;
    logic                        lclk;
    logic                        pulse;
    logic                        dwire;
    logic                        in_prog;
    logic [PIN_N-1:0]            latch;
    logic [PIN_N-1:0]            dir;
    logic [PIN_N-1:0]            port_rd;
    periph_ctl_t                 ctl;
    periph_in_t                  pin_fn;
    logic                        prog_mode;
    logic                        prog_pulse;
    logic [PROG_WORD_W-1:0]      prog_word;
    logic                        prog_word_valid;
    logic [PROG_WORD_W-1:0]      tx_word;
    logic                        prog_tx_taken;
    int                          bad_count;
    int                          n_checks;
    int                          valid_seen;
    int                          taken_seen;

    assign pad_in = in_prog ? {pulse, pins[10:8], lclk, dwire, pins[5:0]} : pins;

    shared_pin_function_mux shared_pin_function_mux_inst (
        .ref_clk(ref_clk), .sys_rst(sys_rst), .pad_in(pad_in), .pad_drive(pad_drive),
        .prog_supply_pin(supply), .reset_pin(rst_pin), .port_latch(latch), .port_dir(dir),
        .port_rd(port_rd), .periph_ctl(ctl), .periph_in(pin_fn), .prog_mode(prog_mode),
        .prog_pulse(prog_pulse), .prog_word(prog_word), .prog_word_valid(prog_word_valid),
        .prog_tx_word(tx_word), .prog_tx_taken(prog_tx_taken)
    );

    prog_model prog_model_inst (
        .ref_clk(ref_clk), .data_drive(pad_drive[PIN_PORT2_BIT0]), .prog_supply_pin(supply),
        .reset_pin(rst_pin), .link_clk(lclk), .pulse_pin(pulse), .data_pin(dwire)
    );

    initial begin
        ref_clk = 1'b0;
        forever #50 ref_clk = ~ref_clk;
    end

    always @(posedge ref_clk) begin
        valid_seen += int'(prog_word_valid === 1'b1);
        taken_seen += int'(prog_tx_taken === 1'b1);
    end

    // ------------------------------------------------------------
    // Compare and closing
    // ------------------------------------------------------------
    task automatic check(input string what, input logic [15:0] exp, input logic [15:0] got);
        n_checks++;
        if (got !== exp) begin
            bad_count++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic wrap_up;
        $display("checks %0d mismatches %0d", n_checks, bad_count);
        if (bad_count == 0 && n_checks > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask

    // ------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------
    task automatic share_test(input periph_ctl_t c, input logic [11:0] p);
        @(negedge ref_clk);
        ctl = c;
        pins = p;
        latch = ~p;
        repeat (8) @(negedge ref_clk);
        check("port_rd", 16'(p), 16'(port_rd));
        check("serial_rx", 16'(c.sio_rx_en & p[0]), 16'(pin_fn.serial_rx));
        check("sio_clk_in", 16'(c.sio_clk_en & !c.sio_clk_out_sel & p[2]), 16'(pin_fn.sio_clk_in));
        check("t1_in", 16'(c.t1_en & !c.t1_out_sel & p[3]), 16'(pin_fn.t1_in));
        check("t0_in", 16'(c.t0_en & !c.t0_out_sel & p[4]), 16'(pin_fn.t0_in));
        check("int_in", 16'(c.int_en & p[5]), 16'(pin_fn.int_in));
        check("p0 drive", 16'({~p[0], 1'b1}), 16'(pad_drive[0]));
        check("tx drive", 16'({c.sio_tx_data, 1'b1}), 16'(pad_drive[1]));
        check("t1 drive", 16'((c.t1_en & c.t1_out_sel) ? {c.t1_out, 1'b1} : {~p[3], 1'b1}), 16'(pad_drive[3]));
        check("t0 drive", 16'((c.t0_en & c.t0_out_sel) ? {c.t0_out, 1'b1} : {~p[4], 1'b1}), 16'(pad_drive[4]));
        check("analog drive", 16'({~p[9], 1'b1, ~p[8], 1'b1}), 16'({pad_drive[9], pad_drive[8]}));
    endtask

    task automatic program_test(input logic [7:0] w);
        valid_seen = 0;
        prog_model_inst.send_word(w);
        repeat (10) @(negedge ref_clk);
        check("prog_word", 16'(w), 16'(prog_word));
        check("valid count", 16'h0001, 16'(valid_seen));
        check("prog_pulse", 16'h0001, 16'(prog_pulse));
    endtask

    task automatic read_test(input logic [7:0] w);
        logic [7:0] got;
        @(negedge ref_clk);
        tx_word = w;
        taken_seen = 0;
        prog_model_inst.read_word(got);
        check("read word", 16'(w), 16'(got));
        check("taken count", 16'h0001, 16'(taken_seen));
        check("prog_pulse low", 16'h0000, 16'(prog_pulse));
    endtask

    initial begin
        #(2000 * 100);
        bad_count++;
        wrap_up;
    end

    initial begin
        sys_rst = 1'b1;
        pins = 12'h000;
        latch = 12'h000;
        dir = 12'hfff;
        ctl = '0;
        tx_word = 8'h00;
        in_prog = 1'b0;
        repeat (12) @(negedge ref_clk);
        sys_rst = 1'b0;
        share_test(13'h1e79, 12'ha5c);
        share_test(13'h1a4f, 12'h5a3);
        in_prog = 1'b1;
        prog_model_inst.enter();
        check("prog_mode on", 16'h0001, 16'(prog_mode));
        program_test(8'ha5);
        program_test(8'h3c);
        read_test(8'hc6);
        prog_model_inst.leave();
        in_prog = 1'b0;
        check("prog_mode off", 16'h0000, 16'(prog_mode));
        wrap_up;
    end
endmodule
